// [include/otpo_defines.vh]
// Constants for the option-bit and programming-mode block
`ifndef OTPO_DEFINES_VH
`define OTPO_DEFINES_VH

// Option cell positions in the option vector
`define OTPO_OPT_PROTECT    0
`define OTPO_OPT_LOW_NOISE  1
`define OTPO_OPT_LATCH_DIS  2
`define OTPO_OPT_PERM_WDT   3
`define OTPO_OPT_LOCKOUT    4
`define OTPO_OPT_W          5

// Cell values: erased option cells and erased code bytes
`define OTPO_OPT_ERASED     5'h00
`define OTPO_CODE_ERASED    8'hff

// Programming mode codes shown on mode_o
`define OTPO_MODE_W         3
`define OTPO_MODE_NONE      3'h0
`define OTPO_MODE_READ      3'h1
`define OTPO_MODE_PROGRAM   3'h2
`define OTPO_MODE_VERIFY    3'h3
`define OTPO_MODE_OPTION    3'h4

// Array geometry
`define OTPO_ADDR_W         10
`define OTPO_DATA_W         8

// Internal clock limit with halving bypassed
`define OTPO_LN_MAX_MHZ     4
`define OTPO_LN_MIN_NS      250

`endif

// [rtl/otpo_option_prog.v]
// Option bits, programming-mode pin decode and code array of the OTP part
// How it works
// RULE1: A burnable option cell selects low-noise operation.
// RULE2: Low noise bypasses the clock halver; system tick runs every cycle.
// RULE3: Outside party keeps crystal at most 4 MHz in low noise.
// RULE4: In programming mode pins become chip enable, output enable, entry, supply, strobe.
// RULE5: Read protect keeps code bytes off the external data pins.
// RULE6: Internal code loads still work under read protect.
// RULE7: External-data loads do not exist; nothing decodes them.
// RULE8: Protect and low noise are separate independent cells.
// RULE9: Latch-disable cell turns off all port input auto latches.
// RULE10: Watchdog cell forces watchdog on from reset, through halt and stop.
// RULE11: Lockout cell blocks programming and factory test entry.
// RULE12: Lockout takes effect only after the next reset, i.e. power cycle.
// RULE13: Read, program and verify chosen by pin levels with address given.
// RULE14: Option burn uses supply and chip enable high voltage, strobe low.
// RULE15: Option cells are sampled at reset and held until the next one.
`timescale 1ns/10ps
`include "otpo_defines.vh"

module otpo_option_prog #(
	parameter ADDR_W = `OTPO_ADDR_W,
	parameter DATA_W = `OTPO_DATA_W,
	parameter DEPTH  = 1024
) (
	// Clock and reset
	input  wire              clk_i,
	input  wire              rst_i,
	// Programming pins: logic level and high-voltage detect
	input  wire              osc_in_pin_i,
	input  wire              osc_in_pin_hv_i,
	input  wire              port3_bit1_pin_i,
	input  wire              port3_bit2_pin_i,
	input  wire              port3_bit2_pin_hv_i,
	input  wire              port3_bit3_pin_hv_i,
	input  wire              port0_bit2_pin_i,
	input  wire [ADDR_W-1:0] prog_addr_i,
	input  wire [DATA_W-1:0] prog_data_i,
	output reg  [DATA_W-1:0] prog_data_o,
	output reg               prog_data_oe_n_o,
	output wire              osc_out_pin_oe_n_o,
	// Core-side requests
	input  wire              test_mode_req_i,
	input  wire              load_code_byte_i,
	input  wire              load_code_byte_autoinc_i,
	input  wire [ADDR_W-1:0] code_addr_i,
	output reg  [DATA_W-1:0] code_data_o,
	input  wire              wdt_sw_en_i,
	input  wire              wdt_halt_en_i,
	input  wire              halt_i,
	input  wire              stop_i,
	// Configuration and status
	output wire              low_noise_o,
	output wire              read_protect_o,
	output wire              auto_latch_en_o,
	output wire              permanent_watchdog_o,
	output wire              watchdog_run_o,
	output wire              prog_lockout_o,
	output wire              test_mode_o,
	output reg               system_and_timer_clock_o,
	output reg  [2:0]        mode_o
);

	// Nonvolatile storage: no reset, it keeps its contents across resets
	reg [DATA_W-1:0]     code_mem [0:DEPTH-1];
	reg [`OTPO_OPT_W-1:0] opt_cells;
	integer i;

	// Power-up contents: erased array and unburned option cells
	initial begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			code_mem[i] = `OTPO_CODE_ERASED;
		end
		opt_cells = `OTPO_OPT_ERASED;
	end

	// Held option copy and load-pending flag
	reg [`OTPO_OPT_W-1:0] opt_q;
	reg                   load_pend_q;
	reg                   strobe_q;
	reg                   div_q;
	reg [2:0]             mode_d;

	// Reset clears the copy; the cells are read at the first edge after
	// release, so the async flop never loads a signal [RULE15]
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			opt_q       <= `OTPO_OPT_ERASED;
			load_pend_q <= 1'b1;
		end else if (load_pend_q) begin
			opt_q       <= opt_cells; // [RULE15] [RULE12]
			load_pend_q <= 1'b0;
		end
	end

	// Each option drives its own output from its own cell [RULE8]
	assign low_noise_o          = opt_q[`OTPO_OPT_LOW_NOISE]; // [RULE1]
	assign read_protect_o       = opt_q[`OTPO_OPT_PROTECT];
	assign auto_latch_en_o      = ~opt_q[`OTPO_OPT_LATCH_DIS]; // [RULE9]
	assign permanent_watchdog_o = opt_q[`OTPO_OPT_PERM_WDT];
	assign prog_lockout_o       = opt_q[`OTPO_OPT_LOCKOUT];

	// Permanent watchdog ignores halt and stop; software one does not
	assign watchdog_run_o = permanent_watchdog_o | // [RULE10]
		(wdt_sw_en_i & ~stop_i & (~halt_i | wdt_halt_en_i));

	// Block both entries while locked or before the options are known
	wire entry_ok = ~prog_lockout_o & ~load_pend_q; // [RULE11]
	assign test_mode_o = test_mode_req_i & entry_ok; // [RULE11]

	// Oscillator output has no use in programming mode: never driven
	assign osc_out_pin_oe_n_o = 1'b1; // [RULE4]

	// Pin roles in programming mode [RULE4]
	// High-voltage levels arrive on their own detect inputs beside the logic
	wire ce_n     = osc_in_pin_i;
	wire ce_hv    = osc_in_pin_hv_i;
	wire oe_n     = port3_bit1_pin_i;
	wire entry    = port3_bit2_pin_i;
	wire entry_hv = port3_bit2_pin_hv_i;
	wire vpp_hv   = port3_bit3_pin_hv_i;
	wire strobe_n = port0_bit2_pin_i;

	// Mode decode from pin levels [RULE13] [RULE14]
	always @* begin
		mode_d = `OTPO_MODE_NONE;
		if (entry_ok) begin
			if (vpp_hv && ce_hv && !strobe_n)
				mode_d = `OTPO_MODE_OPTION; // [RULE14]
			else if (vpp_hv && entry && !entry_hv && !ce_n && !ce_hv) begin
				if (oe_n && !strobe_n)
					mode_d = `OTPO_MODE_PROGRAM; // [RULE13]
				else if (!oe_n && strobe_n)
					mode_d = `OTPO_MODE_VERIFY; // [RULE13]
			end else if (entry_hv && !ce_n && !ce_hv && !oe_n && strobe_n)
				mode_d = `OTPO_MODE_READ; // [RULE13]
		end
	end

	// Mode register and clock halver
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_o   <= `OTPO_MODE_NONE;
			div_q    <= 1'b0;
		end else begin
			mode_o   <= mode_d;
			div_q    <= ~div_q;
		end
	end

	// Strobe history starts at the pin's idle high level, so leaving
	// reset with the strobe held high never looks like a falling edge
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			strobe_q <= 1'b1;
		else
			strobe_q <= strobe_n;
	end

	// Halver bypassed in low noise; crystal must then stay at or below
	// the low-noise limit, which is the programmer's and board's duty
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			system_and_timer_clock_o <= 1'b0;
		else
			system_and_timer_clock_o <= low_noise_o | div_q; // [RULE2]
	end

	// Burn one cell per strobe falling edge; an OTP cell only ever goes
	// from erased to burned, so repeated pulses are harmless
	wire strobe_fall = strobe_q & ~strobe_n;

	// Cell picked by the entry and output-enable levels; entry at high
	// voltage with output enable low names no cell, so nothing burns
	reg [`OTPO_OPT_W-1:0] burn_sel;

	always @* begin
		burn_sel = {`OTPO_OPT_W{1'b0}};
		if (entry_hv) begin
			if (oe_n)
				burn_sel[`OTPO_OPT_PROTECT] = 1'b1; // [RULE14]
		end else if (entry) begin
			if (oe_n)
				burn_sel[`OTPO_OPT_LOW_NOISE] = 1'b1; // [RULE14]
			else
				burn_sel[`OTPO_OPT_LATCH_DIS] = 1'b1; // [RULE14]
		end else if (oe_n)
			burn_sel[`OTPO_OPT_PERM_WDT] = 1'b1; // [RULE14]
		else
			burn_sel[`OTPO_OPT_LOCKOUT] = 1'b1; // [RULE14]
	end

	// Code bits only ever go from erased 1 to burned 0
	always @(posedge clk_i) begin
		if (strobe_fall && mode_d == `OTPO_MODE_PROGRAM)
			code_mem[prog_addr_i] <= code_mem[prog_addr_i] & prog_data_i;
		if (strobe_fall && mode_d == `OTPO_MODE_OPTION)
			opt_cells <= opt_cells | burn_sel; // [RULE14]
	end

	// External read path; protect keeps the pins undriven [RULE5]
	// Verify shares the path, so it is refused under protect too
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prog_data_o      <= {DATA_W{1'b0}};
			prog_data_oe_n_o <= 1'b1;
		end else if ((mode_d == `OTPO_MODE_READ ||
			mode_d == `OTPO_MODE_VERIFY) && !read_protect_o) begin
			prog_data_o      <= code_mem[prog_addr_i]; // [RULE13]
			prog_data_oe_n_o <= 1'b0;
		end else begin
			prog_data_o      <= {DATA_W{1'b0}}; // [RULE5]
			prog_data_oe_n_o <= 1'b1;
		end
	end

	// Internal code loads ignore protect; only code-space loads exist
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			code_data_o <= {DATA_W{1'b0}};
		else if (load_code_byte_i || load_code_byte_autoinc_i)
			code_data_o <= code_mem[code_addr_i]; // [RULE6] [RULE7]
	end

endmodule // otpo_option_prog

// [bench/otpo_asserts.sv]
// Concurrent checks on the option and programming-mode block
`timescale 1ns/10ps
module otpo_asserts (
	input wire       clk_i, rst_i, osc_in_pin_i, port3_bit1_pin_i,
	input wire       port3_bit2_pin_hv_i, port0_bit2_pin_i,
	input wire       prog_data_oe_n_o, osc_out_pin_oe_n_o, low_noise_o,
	input wire       read_protect_o, permanent_watchdog_o, watchdog_run_o,
	input wire       prog_lockout_o, test_mode_o, system_and_timer_clock_o,
	input wire [2:0] mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_osc_out_idle: assert property (osc_out_pin_oe_n_o)
		else $error("osc out driven");
	a_protect_no_drive: assert property (read_protect_o |-> prog_data_oe_n_o)
		else $error("protected data driven");
	a_lockout_blocks: assert property (prog_lockout_o |->
		mode_o == 3'h0 && !test_mode_o) else $error("lockout leaked");
	// Load edge after reset is excluded: entry is still blocked there
	a_read_decode: assert property (!$past(rst_i) && !prog_lockout_o &&
		!read_protect_o && port3_bit2_pin_hv_i && !osc_in_pin_i &&
		!port3_bit1_pin_i && port0_bit2_pin_i |=>
		mode_o == 3'h1 && !prog_data_oe_n_o) else $error("read not decoded");
	a_perm_wdt_runs: assert property (permanent_watchdog_o |-> watchdog_run_o)
		else $error("watchdog stopped");
	a_low_noise_tick: assert property (low_noise_o |=> system_and_timer_clock_o)
		else $error("tick missed");
	a_half_tick: assert property (!low_noise_o && !$past(rst_i) |=>
		$changed(system_and_timer_clock_o)) else $error("tick not halved");
	a_options_held: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
		$stable({low_noise_o, read_protect_o, permanent_watchdog_o,
		prog_lockout_o})) else $error("options moved");
endmodule // otpo_asserts
bind otpo_option_prog otpo_asserts u_chk (.clk_i, .rst_i, .osc_in_pin_i,
	.port3_bit1_pin_i, .port3_bit2_pin_hv_i, .port0_bit2_pin_i,
	.prog_data_oe_n_o, .osc_out_pin_oe_n_o, .low_noise_o, .read_protect_o,
	.permanent_watchdog_o, .watchdog_run_o, .prog_lockout_o, .test_mode_o,
	.system_and_timer_clock_o, .mode_o);

// [bench/otpo_programmer.sv]
// Behavioural programmer driving the OTP programming pins
`timescale 1ns/10ps
module otpo_programmer (
	input  wire clk_i,
	output wire ce_n_o, ce_hv_o, oe_n_o, ent_o, ent_hv_o, vpp_hv_o, pgm_n_o
);
	reg [6:0] p = 7'h51;
	// Idle pattern selects no mode and keeps the strobe high
	assign {ce_n_o, ce_hv_o, oe_n_o, ent_o, ent_hv_o, vpp_hv_o, pgm_n_o} = p;
	// Hold one pattern for n edges; n above 1 acts as a slow programmer
	task access(input [6:0] pins, input int n);
		@(posedge clk_i) #5;
		p = pins;
		repeat (n) @(posedge clk_i);
		#5 p = 7'h51;
	endtask
endmodule // otpo_programmer

// [bench/test_otpo_option_prog.sv]
// Self-checking bench for the option and programming-mode block
`timescale 1ns/10ps
`include "otpo_defines.vh"
module test_otpo_option_prog;
	reg        clk_i = 1'b0, rst_i = 1'b1, lcb = 1'b0, hlt = 1'b0;
	reg        stp = 1'b1;
	reg  [9:0] addr = 10'h000;
	reg  [7:0] din = 8'h00, e, q [$];
	reg  [4:0] opt = 5'h00;
	reg  [6:0] burn [5] = '{7'h7e, 7'h7a, 7'h6a, 7'h72, 7'h62};
	wire       ce_n_o, ce_hv_o, oe_n_o, ent_o, ent_hv_o, vpp_hv_o, pgm_n_o;
	wire       doe_n, ln, rp, pw, lk, ale, wr, tm;
	wire [7:0] dout, cdat;
	wire [7:0] o = {3'h0, lk, pw, ~ale, ln, rp};
	int        failures = 0, compares = 0, i;
	int        hp = 50;
	always #hp clk_i = ~clk_i;
	otpo_programmer P (.clk_i, .ce_n_o, .ce_hv_o, .oe_n_o, .ent_o,
		.ent_hv_o, .vpp_hv_o, .pgm_n_o);
	otpo_option_prog DUT (.clk_i, .rst_i, .osc_in_pin_i(ce_n_o),
		.osc_in_pin_hv_i(ce_hv_o), .port3_bit1_pin_i(oe_n_o),
		.port3_bit2_pin_i(ent_o), .port3_bit2_pin_hv_i(ent_hv_o),
		.port3_bit3_pin_hv_i(vpp_hv_o), .port0_bit2_pin_i(pgm_n_o),
		.prog_addr_i(addr), .prog_data_i(din), .prog_data_o(dout),
		.prog_data_oe_n_o(doe_n), .osc_out_pin_oe_n_o(),
		.test_mode_req_i(1'b1), .load_code_byte_i(1'b0),
		.load_code_byte_autoinc_i(lcb), .code_addr_i(addr),
		.code_data_o(cdat), .wdt_sw_en_i(1'b1), .wdt_halt_en_i(hlt),
		.halt_i(hlt), .stop_i(stp), .low_noise_o(ln), .read_protect_o(rp),
		.auto_latch_en_o(ale), .permanent_watchdog_o(pw),
		.watchdog_run_o(wr), .prog_lockout_o(lk), .test_mode_o(tm),
		.system_and_timer_clock_o(), .mode_o());
	task check(input string nm, input [7:0] seen, input [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Power cycle: option cells are only sampled as reset lets go
	task reboot;
		@(posedge clk_i) #5 rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#5 rst_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#5;
	endtask
	// Every driven data cycle retires the oldest expected byte
	always @(negedge clk_i)
		if (doe_n === 1'b0)
			check("data", dout, q.size() ? q.pop_front() : 8'hxx);
	// Tests need about 90 cycles; this limit is far beyond that
	initial begin
		#100000;
		failures++;
		close_out();
	end
	initial begin
		i = $urandom(32'h40de);
		reboot();
		addr = 10'($urandom);
		q.push_back(8'hff);
		P.access(7'h0d, 1);
		e = 8'hff;
		// Two burns into one byte can only clear bits
		repeat (2) begin
			din = 8'($urandom);
			e = e & din;
			P.access(7'h1a, 1);
		end
		repeat (4) q.push_back(e);
		P.access(7'h0b, 3);
		P.access(7'h0d, 1);
		// Each option waits for a power cycle, then blocks what it should
		for (i = 0; i < 5; i++) begin
			hlt = 1'($urandom);
			stp = 1'($urandom);
			P.access(burn[i], 1);
			check("options held", o, {3'h0, opt});
			opt[i] = 1'b1;
			// Low noise runs the core at crystal rate: slow it to the limit
			if (opt[1]) hp = `OTPO_LN_MIN_NS / 2;
			reboot();
			check("options", o, {3'h0, opt});
			check("watchdog", {7'h0, wr}, {7'h0, opt[3] | ~stp});
			check("test mode", {7'h0, tm}, {7'h0, ~opt[4]});
			P.access(7'h0d, 1);
			@(posedge clk_i) #5 lcb = 1'b1;
			@(posedge clk_i) #5 lcb = 1'b0;
			@(posedge clk_i) #5 check("code", cdat, e);
		end
		check("pending", 8'(q.size()), 8'h00);
		close_out();
	end
endmodule // test_otpo_option_prog
